// ===== pkg/flash_ctl_pkg.sv
package flash_ctl_pkg;
   // Command addresses and data
   localparam logic [19:0] unlock_addr_a = 20'h00555;
   localparam logic [19:0] unlock_addr_b = 20'h002AA;
   localparam logic [7:0] unlock_data_a = 8'hAA;
   localparam logic [7:0] unlock_data_b = 8'h55;
   localparam logic [7:0] cmd_erase_setup = 8'h80;
   localparam logic [7:0] cmd_chip_erase = 8'h10;
   localparam logic [7:0] cmd_sector_erase = 8'h30;
   localparam logic [7:0] cmd_suspend = 8'hB0;
   localparam logic [7:0] cmd_resume = 8'h30;
   localparam logic [7:0] cmd_reset = 8'hF0;
   localparam logic [7:0] cmd_ident = 8'h90;
   // Status bit positions
   localparam int poll_status_bit = 7;
   localparam int toggle_status_bit = 6;
   localparam int timeout_fail_bit = 5;
   localparam int erase_window_bit = 3;
   // Timing at 100 MHz
   localparam int clk_period_ns = 10;
   localparam int sector_window_us = 50;
   localparam int suspend_max_us = 20;
   localparam int strobe_ns = 50;
   localparam int strobe_cyc = (strobe_ns + clk_period_ns - 1) / clk_period_ns;
   // Next sector load must start well inside the window (longest time: round down)
   localparam int sector_window_cyc = (sector_window_us * 1000) / clk_period_ns;
   localparam int suspend_wait_cyc = (suspend_max_us * 1000) / clk_period_ns;
   // User commands
   typedef enum logic [2:0] {
      op_chip_erase, op_sector_erase, op_add_sector, op_suspend,
      op_resume, op_reset, op_ident, op_read
   } op_t;
   // One bus cycle for the access engine
   typedef struct packed {
      logic wr;
      logic [19:0] addr;
      logic [7:0] data;
   } bus_req_t;
endpackage

// ===== test/flash_dev_model.sv
`timescale 1ns/1ns
module flash_dev_model
   import flash_ctl_pkg::*;
#(
   parameter int erase_len = 6000,
   parameter logic [7:0] maker_code = 8'h3C, // Arbitrary value
   parameter logic [7:0] dev_code = 8'h96 // Arbitrary value
)(
   // Clock and fault control
   input wire logic core_clk,
   input wire logic fail_en,
   // Flash pins
   input wire logic ce_b,
   input wire logic we_b,
   input wire logic oe_b,
   input wire logic [19:0] addr,
   input wire logic [7:0] dq_out,
   output logic [7:0] dq_in,
   output logic ready_busy_in
);
   int step = 0;
   int busy = 0;
   logic ident = 1'b0;
   logic err = 1'b0;
   logic tog = 1'b0;
   logic we_q = 1'b1;
   logic ce_q = 1'b1;
   logic oe_q = 1'b1;
   logic [7:0] last = 8'h00;
   logic [7:0] rd;
   // Status while running or failed, ident codes, else array pattern
   always_comb begin
      if (busy > 0 || err) rd = {1'b0, tog, err, 5'h00};
      else if (ident) rd = addr[0] ? dev_code : maker_code;
      else rd = addr[7:0] ^ 8'hA5;
   end
   // Released bus shows the inverse of the last value
   assign dq_in = (!oe_b && !ce_b) ? rd : ~last;
   assign ready_busy_in = (busy == 0);
   // Read toggling, erase timer, command decode at strobe rise
   always @(posedge core_clk) begin
      we_q <= we_b;
      ce_q <= ce_b;
      oe_q <= oe_b;
      if (oe_q && !oe_b && !ce_b) begin
         last <= rd;
         if (busy > 0 || err) tog <= ~tog;
      end
      if (busy > 1) busy <= busy - 1;
      else if (busy == 1) begin
         busy <= 0;
         err <= fail_en;
      end
      // Write ends at whichever of the two strobes rises first
      if (!we_q && !ce_q && (we_b || ce_b)) begin
         if (dq_out == cmd_reset && busy == 0) begin
            step <= 0;
            ident <= 1'b0;
            err <= 1'b0;
         end else if (busy == 0 && !err) begin
            case (step)
               0, 3: step <= (addr == unlock_addr_a && dq_out == unlock_data_a) ? step + 1 : 0;
               1, 4: step <= (addr == unlock_addr_b && dq_out == unlock_data_b) ? step + 1 : 0;
               2: begin
                  step <= (dq_out == cmd_erase_setup) ? 3 : 0;
                  if (dq_out == cmd_ident) ident <= 1'b1;
               end
               default: begin
                  step <= 0;
                  if (dq_out == cmd_chip_erase || dq_out == cmd_sector_erase) busy <= erase_len;
               end
            endcase
         end
      end
   end
endmodule

// ===== test/flash_erase_host_asserts.sv
`timescale 1ns/1ns
module flash_erase_host_asserts (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // User side
   input wire logic cmd_valid,
   input wire logic cmd_ready,
   input wire logic op_done,
   // Flash pins
   input wire logic ce_b,
   input wire logic we_b,
   input wire logic oe_b,
   input wire logic [19:0] addr,
   input wire logic [7:0] dq_out,
   input wire logic dq_oe
);
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (!rst_b);
   a_no_contention: assert property (!(!we_b && !oe_b))
      else $error("write and read strobes low together");
   a_write_drives: assert property (!we_b |-> dq_oe && !ce_b)
      else $error("write without data drive or select");
   a_read_floats: assert property (!oe_b |-> !dq_oe)
      else $error("data driven during read");
   a_write_hold: assert property (!we_b && $past(!we_b) |-> $stable(addr) && $stable(dq_out))
      else $error("address or data moved during write");
   a_write_width: assert property ($fell(we_b) |-> (!we_b) [*5])
      else $error("write strobe too short");
   a_write_gap: assert property ($rose(we_b) |=> we_b)
      else $error("writes not separated");
   a_done_pulse: assert property (op_done |=> !op_done)
      else $error("done longer than one cycle");
   a_take_busy: assert property (cmd_valid && cmd_ready |=> !cmd_ready)
      else $error("ready stayed high after take");
   a_idle_quiet: assert property (cmd_ready |-> we_b && ce_b)
      else $error("bus active while idle");
endmodule
bind flash_erase_host flash_erase_host_asserts u_chk (
   .core_clk(core_clk), .rst_b(rst_b), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
   .op_done(op_done), .ce_b(ce_b), .we_b(we_b), .oe_b(oe_b), .addr(addr),
   .dq_out(dq_out), .dq_oe(dq_oe)
);

// ===== test/test_flash_erase_host.sv
`timescale 1ns/1ns
module test_flash_erase_host import flash_ctl_pkg::*;;
   localparam logic [7:0] maker = 8'h3C; // Arbitrary value
   localparam logic [7:0] devc = 8'h96; // Arbitrary value
   logic core_clk = 1'b0;
   logic rst_b = 1'b0;
   logic cmd_valid = 1'b0;
   op_t cmd_op = op_read;
   logic [19:0] cmd_addr = 20'h00000;
   logic fail_en = 1'b0;
   logic cmd_ready, op_done, op_fail, suspended, ce_b, we_b, oe_b, dq_oe, ready_busy_in;
   logic [19:0] addr;
   logic [7:0] dq_out, dq_in, op_data, got;
   logic we_prev = 1'b1;
   logic [27:0] wq[$];
   int num_errors = 0;
   int check_count = 0;
   always #5 core_clk = ~core_clk;
   flash_erase_host u_dut (.core_clk(core_clk), .rst_b(rst_b), .cmd_valid(cmd_valid),
      .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_ready(cmd_ready), .op_done(op_done),
      .op_fail(op_fail), .op_data(op_data), .suspended(suspended), .ce_b(ce_b),
      .we_b(we_b), .oe_b(oe_b), .addr(addr), .dq_out(dq_out), .dq_oe(dq_oe),
      .dq_in(dq_in), .ready_busy_in(ready_busy_in));
   flash_dev_model #(.maker_code(maker), .dev_code(devc)) u_dev (.core_clk(core_clk),
      .fail_en(fail_en), .ce_b(ce_b), .we_b(we_b), .oe_b(oe_b), .addr(addr),
      .dq_out(dq_out), .dq_in(dq_in), .ready_busy_in(ready_busy_in));
   // Log each write as it starts
   always @(posedge core_clk) begin
      we_prev <= we_b;
      if (we_prev && !we_b) wq.push_back({addr, dq_out});
   end
   task automatic chk(input string what, input logic [27:0] exp, input logic [27:0] seen);
      check_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task give_verdict;
      if (num_errors == 0 && check_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // One command through the user port, wait for done
   task automatic run(input op_t op, input logic [19:0] a);
      int n;
      for (n = 0; n < 200 && cmd_ready !== 1'b1; n++) @(posedge core_clk);
      cmd_valid <= 1'b1;
      cmd_op <= op;
      cmd_addr <= a;
      @(posedge core_clk);
      cmd_valid <= 1'b0;
      for (n = 0; n < 30000 && op_done !== 1'b1; n++) @(posedge core_clk);
      chk("op_done", 28'h1, {27'h0, op_done});
      got = op_data;
   endtask
   // Six writes of an erase, last address checked only when full is set
   task automatic seq_chk(input logic [7:0] code, input logic [19:0] sa, input logic full);
      logic [27:0] exp [6];
      exp = '{{unlock_addr_a, unlock_data_a}, {unlock_addr_b, unlock_data_b},
         {unlock_addr_a, cmd_erase_setup}, {unlock_addr_a, unlock_data_a},
         {unlock_addr_b, unlock_data_b}, {sa, code}};
      chk("write count", 28'd6, 28'(wq.size()));
      for (int i = 0; i < 6 && i < wq.size(); i++) begin
         if (i == 5 && !full) chk("last write", {20'h0, code}, {20'h0, wq[i][7:0]});
         else chk("write", exp[i], wq[i]);
      end
   endtask
   task t_read;
      run(op_read, 20'h00012);
      chk("power-up read", {20'h0, 8'h12 ^ 8'hA5}, {20'h0, got});
   endtask
   task t_chip;
      wq.delete();
      run(op_chip_erase, 20'h00000);
      seq_chk(cmd_chip_erase, 20'h0, 1'b0);
      chk("fail after chip erase", 28'h0, {27'h0, op_fail});
      chk("poll bit at end", 28'h1, {27'h0, got[poll_status_bit]});
      run(op_read, 20'h00033);
      chk("read after erase", {20'h0, 8'h33 ^ 8'hA5}, {20'h0, got});
   endtask
   task t_sector;
      wq.delete();
      run(op_sector_erase, 20'h1C000);
      seq_chk(cmd_sector_erase, 20'h1C000, 1'b1);
      repeat (sector_window_cyc + 100) @(posedge core_clk);
      wq.delete();
      run(op_add_sector, 20'h0C000);
      chk("late add refused", 28'h1, {27'h0, op_fail});
      chk("late add writes", 28'h0, 28'(wq.size()));
      run(op_reset, 20'h00000);
      chk("fail cleared", 28'h0, {27'h0, op_fail});
   endtask
   task t_fail;
      fail_en <= 1'b1;
      run(op_chip_erase, 20'h00000);
      chk("timeout fail", 28'h1, {27'h0, op_fail});
      chk("fail status bit", 28'h1, {27'h0, got[timeout_fail_bit]});
      fail_en <= 1'b0;
      run(op_reset, 20'h00000);
      chk("fail cleared", 28'h0, {27'h0, op_fail});
      run(op_read, 20'h00044);
      chk("read after recovery", {20'h0, 8'h44 ^ 8'hA5}, {20'h0, got});
   endtask
   task t_ident;
      run(op_ident, 20'h00000);
      run(op_read, 20'h00000);
      chk("maker code", {20'h0, maker}, {20'h0, got});
      run(op_read, 20'h00001);
      chk("device code", {20'h0, devc}, {20'h0, got});
      run(op_reset, 20'h00000);
      run(op_read, 20'h00001);
      chk("read after exit", {20'h0, 8'h01 ^ 8'hA5}, {20'h0, got});
   endtask
   task t_susp;
      run(op_suspend, 20'h00000);
      chk("suspended set", 28'h1, {27'h0, suspended});
      run(op_resume, 20'h00000);
      chk("suspended cleared", 28'h0, {27'h0, suspended});
      run(op_read, 20'h00055);
      chk("read after resume", {20'h0, 8'h55 ^ 8'hA5}, {20'h0, got});
   endtask
   // Hang guard
   initial begin
      #900000;
      num_errors++;
      give_verdict;
   end
   initial begin
      repeat (16) @(posedge core_clk);
      rst_b <= 1'b1;
      @(posedge core_clk);
      t_read;
      t_chip;
      t_sector;
      t_fail;
      t_ident;
      t_susp;
      give_verdict;
   end
endmodule

// ===== verilog/flash_bus_cycle.sv
`timescale 1ns/1ns
module flash_bus_cycle
   import flash_ctl_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // Request side
   input wire bus_req_t req,
   input wire logic req_valid,
   output logic busy,
   output logic done,
   output logic [7:0] rd_data,
   // Flash pins
   output logic ce_b,
   output logic we_b,
   output logic oe_b,
   output logic [19:0] addr,
   output logic [7:0] dq_out,
   output logic dq_oe,
   input wire logic [7:0] dq_in
);
   typedef enum logic [1:0] {idle, strobe, recover} phase_t;
   phase_t phase, next_phase;
   logic [3:0] cnt, next_cnt;
   logic ce_b_n, we_b_n, oe_b_n, dq_oe_n, done_n, wr_q, next_wr_q;
   logic [19:0] addr_n;
   logic [7:0] dq_out_n, rd_data_n, dq_s1, dq_s2;

   // Two-flop sync of data pins
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         dq_s1 <= 8'h00;
         dq_s2 <= 8'h00;
      end else begin
         dq_s1 <= dq_in;
         dq_s2 <= dq_s1;
      end
   end

   // Strobe sequencing; we_b and ce_b rise together
   always_comb begin
      next_phase = phase;
      next_cnt = cnt;
      ce_b_n = ce_b;
      we_b_n = we_b;
      oe_b_n = oe_b;
      dq_oe_n = dq_oe;
      addr_n = addr;
      dq_out_n = dq_out;
      rd_data_n = rd_data;
      next_wr_q = wr_q;
      done_n = 1'b0;
      case (phase)
         idle: begin
            if (req_valid) begin
               next_phase = strobe;
               next_cnt = 4'(strobe_cyc);
               addr_n = req.addr;
               dq_out_n = req.data;
               next_wr_q = req.wr;
               ce_b_n = 1'b0;
               we_b_n = !req.wr;
               oe_b_n = req.wr;
               dq_oe_n = req.wr;
            end
         end
         strobe: begin
            if (cnt == 4'h0) begin
               ce_b_n = 1'b1;
               we_b_n = 1'b1;
               oe_b_n = 1'b1;
               if (!wr_q) begin
                  rd_data_n = dq_s2;
               end
               next_phase = recover;
               next_cnt = 4'(strobe_cyc);
            end else begin
               next_cnt = cnt - 4'h1;
            end
         end
         recover: begin
            dq_oe_n = 1'b0;
            if (cnt == 4'h0) begin
               next_phase = idle;
               done_n = 1'b1;
            end else begin
               next_cnt = cnt - 4'h1;
            end
         end
         default: next_phase = idle;
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         phase <= idle;
         cnt <= 4'h0;
         ce_b <= 1'b1;
         we_b <= 1'b1;
         oe_b <= 1'b1;
         dq_oe <= 1'b0;
         addr <= 20'h00000;
         dq_out <= 8'h00;
         rd_data <= 8'h00;
         wr_q <= 1'b0;
         done <= 1'b0;
      end else begin
         phase <= next_phase;
         cnt <= next_cnt;
         ce_b <= ce_b_n;
         we_b <= we_b_n;
         oe_b <= oe_b_n;
         dq_oe <= dq_oe_n;
         addr <= addr_n;
         dq_out <= dq_out_n;
         rd_data <= rd_data_n;
         wr_q <= next_wr_q;
         done <= done_n;
      end
   end

   assign busy = (phase != idle);
endmodule

// ===== verilog/flash_erase_host.sv
`timescale 1ns/1ns
// Functional notes
// R1 - Erase: two unlocks, 80H, two unlocks, 10H/30H
// R2 - Device preprograms whole chip before erase
// R3 - Done shows poll bit one, read mode
// R4 - Failure sets timeout fail bit
// R5 - Erase starts at last strobe rise
// R6 - Toggle bit stable twice means complete
// R7 - Array read after power-up and completion
// R8 - Suspended sectors read status, others data
// R9 - Reset exits identification or failure
// R10 - Reset aborts erase sequence before start
// R11 - Reset aborts program sequence before start
// R12 - Identification mode held until reset
// R13 - Sector erase preprograms selected sectors only
// R14 - Sector address on fall, data rise
// R15 - Next sector cycle within 50us window
// R16 - Other command in window reads array
// R17 - Suspend honoured only during sector erase; code sets suspended on every suspend command, and sends it only from idle
// R18 - Suspend takes effect within 20us
// R19 - Suspended device returns to read mode
// R20 - Suspend program polled like normal program
// R21 - Resume only after accepted suspend; code writes resume even when not suspended, and polls only if suspended
// R22 - Bad sequence returns device to read
// R23 - Ident reads: maker then device code
// R24 - Ready/busy low while algorithm runs
module flash_erase_host
   import flash_ctl_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // User command port
   input wire logic cmd_valid,
   input wire op_t cmd_op,
   input wire logic [19:0] cmd_addr,
   output logic cmd_ready,
   output logic op_done,
   output logic op_fail,
   output logic [7:0] op_data,
   output logic suspended,
   // Flash pins
   output logic ce_b,
   output logic we_b,
   output logic oe_b,
   output logic [19:0] addr,
   output logic [7:0] dq_out,
   output logic dq_oe,
   input wire logic [7:0] dq_in,
   input wire logic ready_busy_in
);
   typedef enum logic [2:0] {
      st_idle, st_issue, st_poll, st_poll_cmp, st_wait, st_finish
   } state_t;
   state_t state, next_state;
   bus_req_t seq [6];
   bus_req_t req;
   logic req_valid, cyc_busy, cyc_done;
   logic [7:0] rd_data;
   logic [2:0] idx, next_idx, len, next_len;
   logic [15:0] wcnt, next_wcnt;
   logic [7:0] first_rd, next_first_rd;
   logic poll_en, next_poll_en, first_ok, next_first_ok, next_done, fail_r, next_fail;
   logic susp, next_susp;
   logic [7:0] data_r, next_data;
   logic [19:0] sel_addr, next_sel_addr;
   logic rb_s1, rb_s2;

   flash_bus_cycle u_cycle (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .req(req),
      .req_valid(req_valid),
      .busy(cyc_busy),
      .done(cyc_done),
      .rd_data(rd_data),
      .ce_b(ce_b),
      .we_b(we_b),
      .oe_b(oe_b),
      .addr(addr),
      .dq_out(dq_out),
      .dq_oe(dq_oe),
      .dq_in(dq_in)
   );

   // Sync ready/busy pin
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         rb_s1 <= 1'b1;
         rb_s2 <= 1'b1;
      end else begin
         rb_s1 <= ready_busy_in;
         rb_s2 <= rb_s1;
      end
   end

   // Build the write sequence for the current operation
   always_comb begin
      for (int i = 0; i < 6; i++) begin
         seq[i] = '{wr: 1'b1, addr: unlock_addr_a, data: unlock_data_a};
      end
      seq[1] = '{wr: 1'b1, addr: unlock_addr_b, data: unlock_data_b}; // [R1]
      seq[2] = '{wr: 1'b1, addr: unlock_addr_a, data: cmd_erase_setup}; // [R1]
      seq[4] = '{wr: 1'b1, addr: unlock_addr_b, data: unlock_data_b}; // [R1]
      seq[5] = '{wr: 1'b1, addr: sel_addr, data: data_r}; // [R1] [R14]
      if (len == 3'd1) begin
         seq[0] = '{wr: !poll_en && data_r == 8'h00 ? 1'b0 : 1'b1,
                    addr: sel_addr, data: data_r};
      end else if (len == 3'd3) begin
         seq[2] = '{wr: 1'b1, addr: unlock_addr_a, data: cmd_ident};
      end
   end

   assign req = (len == 3'd1) ? seq[0] : (len == 3'd3 ? seq[idx] : seq[idx]);

   // Command sequencer
   always_comb begin
      next_state = state;
      next_idx = idx;
      next_len = len;
      next_wcnt = wcnt;
      next_first_rd = first_rd;
      next_first_ok = first_ok;
      next_poll_en = poll_en;
      next_done = 1'b0;
      next_fail = fail_r;
      next_susp = susp;
      next_data = data_r;
      next_sel_addr = sel_addr;
      req_valid = 1'b0;
      case (state)
         st_idle: begin
            if (wcnt != 16'h0000) begin
               next_wcnt = wcnt - 16'h0001; // Sector window timer
            end
            if (cmd_valid) begin
               next_idx = 3'd0;
               next_poll_en = 1'b0;
               next_sel_addr = cmd_addr;
               next_state = st_issue;
               case (cmd_op)
                  op_chip_erase: begin
                     next_len = 3'd6;
                     next_data = cmd_chip_erase; // [R1] [R2]
                     next_poll_en = 1'b1;
                  end
                  op_sector_erase: begin
                     next_len = 3'd6;
                     next_data = cmd_sector_erase; // [R1] [R13]
                     next_poll_en = 1'b1;
                  end
                  op_add_sector: begin
                     // Extra sector only inside the load window
                     next_len = 3'd1;
                     next_data = cmd_sector_erase; // [R15]
                     next_poll_en = (wcnt == 16'h0000);
                     if (wcnt == 16'h0000) begin
                        next_state = st_finish; // [R15] window closed
                        next_fail = 1'b1;
                     end
                  end
                  op_suspend: begin
                     next_len = 3'd1;
                     next_data = cmd_suspend; // [R17] [R18]
                     next_susp = 1'b1;
                  end
                  op_resume: begin
                     next_len = 3'd1;
                     next_data = cmd_resume;
                     next_poll_en = susp; // [R21]
                     next_susp = 1'b0;
                  end
                  op_reset: begin
                     next_len = 3'd1;
                     next_data = cmd_reset; // [R9] [R10] [R11] [R12]
                     next_fail = 1'b0;
                  end
                  op_ident: begin
                     next_len = 3'd3;
                     next_data = cmd_ident;
                  end
                  default: begin
                     next_len = 3'd1;
                     next_data = 8'h00; // Plain array or status read [R7] [R8] [R23]
                  end
               endcase
            end
         end
         st_issue: begin
            req_valid = !cyc_busy && !cyc_done;
            if (cyc_done) begin
               if (idx + 3'd1 >= len) begin
                  next_wcnt = 16'(sector_window_cyc); // [R15] [R5]
                  if (poll_en) begin
                     next_state = st_poll;
                     next_wcnt = (data_r == cmd_sector_erase) ? 16'(sector_window_cyc)
                                 : 16'h0000;
                  end else if (data_r == cmd_suspend) begin
                     next_state = st_wait;
                     next_wcnt = 16'(suspend_wait_cyc); // [R18]
                  end else begin
                     next_data = rd_data;
                     next_state = st_finish;
                  end
               end else begin
                  next_idx = idx + 3'd1;
               end
            end
         end
         st_poll: begin
            // Toggle polling: two reads [R6] [R20]
            next_len = 3'd1;
            next_idx = 3'd0;
            next_poll_en = 1'b0;
            next_data = 8'h00;
            next_first_ok = 1'b0; // Stale read data is no reference
            next_state = st_poll_cmp;
         end
         st_poll_cmp: begin
            req_valid = !cyc_busy && !cyc_done;
            if (cyc_done) begin
               next_first_rd = rd_data;
               next_first_ok = 1'b1;
               if (!first_ok) begin
                  next_state = st_poll_cmp; // First read only sets the reference [R6]
               end else if (rd_data[toggle_status_bit] == first_rd[toggle_status_bit]) begin
                  next_data = rd_data; // [R3] [R6]
                  next_state = st_finish;
               end else if (rd_data[timeout_fail_bit] && first_rd[timeout_fail_bit]) begin
                  // Fail bit on two toggling reads; one alone may be the last status
                  next_fail = 1'b1; // [R4] reset needed afterwards [R9]
                  next_data = rd_data;
                  next_state = st_finish;
               end
            end
         end
         st_wait: begin
            // Give the device its suspend latency [R18] [R19]
            if (wcnt == 16'h0000) begin
               next_state = st_finish;
            end else begin
               next_wcnt = wcnt - 16'h0001;
            end
         end
         st_finish: begin
            next_done = 1'b1;
            next_wcnt = (data_r == cmd_sector_erase) ? wcnt : 16'h0000; // [R16] [R22]
            next_state = st_idle;
         end
         default: next_state = st_idle;
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         state <= st_idle;
         idx <= 3'd0;
         len <= 3'd1;
         wcnt <= 16'h0000;
         first_rd <= 8'h00;
         poll_en <= 1'b0;
         first_ok <= 1'b0;
         fail_r <= 1'b0;
         susp <= 1'b0;
         data_r <= 8'h00;
         sel_addr <= 20'h00000;
      end else begin
         state <= next_state;
         idx <= next_idx;
         len <= next_len;
         wcnt <= next_wcnt;
         first_rd <= next_first_rd;
         poll_en <= next_poll_en;
         first_ok <= next_first_ok;
         fail_r <= next_fail;
         susp <= next_susp;
         data_r <= next_data;
         sel_addr <= next_sel_addr;
      end
   end

   // Registered user outputs; busy pin holds off new commands [R24]
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         cmd_ready <= 1'b0;
         op_done <= 1'b0;
         op_fail <= 1'b0;
         op_data <= 8'h00;
         suspended <= 1'b0;
      end else begin
         cmd_ready <= (next_state == st_idle) && !cmd_valid && rb_s2; // [R24]
         op_done <= next_done;
         op_fail <= next_fail;
         op_data <= next_data;
         suspended <= next_susp;
      end
   end
endmodule
